// File: design/teci_pkg.sv
/*
 Shared constants and types for the tape erase check and inquiry block.
 Assumes one clock domain, a synchronous active-high reset, and a command source on the same clock.
*/
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package teci_pkg;

    // Opcodes and status codes.
    localparam logic [7:0] TECI_OP_INQUIRY = 8'h12;
    localparam logic [7:0] TECI_OP_ERASE = 8'h19;
    localparam logic [7:0] TECI_ST_GOOD = 8'h00;
    localparam logic [7:0] TECI_ST_CHECK = 8'h02;
    localparam logic [7:0] TECI_ST_CONFLICT = 8'h18;
    localparam logic [3:0] TECI_SK_NONE = 4'h0;
    localparam logic [3:0] TECI_SK_ILLEGAL = 4'h5;
    localparam logic [3:0] TECI_SK_UNIT_ATTN = 4'h6;

    // Field positions inside the command block.
    localparam int TECI_VPD_BIT = 0;
    localparam int TECI_LONG_BIT = 0;
    localparam int TECI_LUN_LSB = 5;

    // Page codes and response sizes.
    localparam logic [7:0] TECI_PAGE_LIST = 8'h00;
    localparam logic [7:0] TECI_PAGE_SERIAL = 8'h80;
    localparam logic [7:0] TECI_LEN_STD = 8'h6a;
    localparam logic [7:0] TECI_LEN_LIST = 8'h06;
    localparam logic [7:0] TECI_LEN_SERIAL = 8'h0e;
    localparam logic [7:0] TECI_TYPE_TAPE = 8'h01;
    localparam logic [7:0] TECI_TYPE_BADLUN = 8'h7f;

    // Power-up limit for inquiry readiness.
    localparam int TECI_POWERUP_S = 3;
    localparam longint TECI_CLK_HZ = 200000000;
    localparam longint TECI_POWERUP_CYC = TECI_POWERUP_S * TECI_CLK_HZ;

    // Values after reset.
    localparam logic TECI_UA_RESET = 1'b1;
    localparam logic [7:0] TECI_CNT_RESET = 8'h00;

    // Recorded format of the loaded tape, oldest first.
    typedef enum logic [1:0] {
        TECI_FMT_OLD = 2'h0,
        TECI_FMT_OLDC = 2'h1,
        TECI_FMT_MID = 2'h2,
        TECI_FMT_NATIVE = 2'h3
    } teci_fmt_t;

    // Class of the current tape position.
    typedef enum logic [2:0] {
        TECI_POS_TAPE_START = 3'h0,
        TECI_POS_PART_START = 3'h1,
        TECI_POS_EOD = 3'h2,
        TECI_POS_LFM_FRONT = 3'h3,
        TECI_POS_LFM_BACK = 3'h4,
        TECI_POS_SM_FRONT = 3'h5,
        TECI_POS_SM_BACK = 3'h6,
        TECI_POS_OTHER = 3'h7
    } teci_pos_t;

    // Six-byte command block.
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] flags;
        logic [7:0] page;
        logic [7:0] rsvd;
        logic [7:0] alloc;
        logic [7:0] control;
    } teci_cmd_t;

    // One response byte on its way to the data-in phase.
    typedef struct packed {
        logic last;
        logic [1:0] sel;
        logic [6:0] index;
        logic [7:0] data;
    } teci_byte_t;

    // Completion report.
    typedef struct packed {
        logic [7:0] status;
        logic [3:0] sense_key;
    } teci_done_t;

endpackage

// File: design/teci_fifo.sv
/*
 Small synchronous FIFO with valid and ready on both sides.
 Assumes both sides run on the one clock and reset.
*/
`timescale 1ns/1ps
module teci_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic srst_in,
    // Fill side.
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side.
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready_out = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_reg != '0);
    assign out_data_out = mem_reg[rd_reg];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    // Storage is written only on an accepted push.
    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data_in;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// File: design/teci_core.sv
/*
 Command checker for erase and inquiry of a sequential-access tape drive.
 Assumes commands, tape position and reset events arrive from logic on mclk_in,
 and that a downstream data-in engine drains the response stream.
*/
`timescale 1ns/1ps
module teci_core
    import teci_pkg::*;
#(
    parameter longint POWERUP_CYC = TECI_POWERUP_CYC,
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic srst_in,
    // Command port.
    input wire logic cmd_valid_in,
    input wire teci_cmd_t cmd_in,
    input wire logic [2:0] ident_lun_in,
    output logic cmd_ready_out,
    // Drive state.
    input wire teci_fmt_t fmt_in,
    input wire teci_pos_t pos_in,
    input wire logic eod_present_in,
    input wire logic reserved_other_in,
    input wire logic attn_event_in,
    // Tape motion handshakes.
    output logic eod_write_out,
    input wire logic eod_done_in,
    output logic erase_start_out,
    // Response stream.
    output logic resp_valid_out,
    output teci_byte_t resp_out,
    input wire logic resp_ready_in,
    // Completion.
    output logic done_valid_out,
    output teci_done_t done_out,
    output logic attn_pending_out
);
    //------------------------------------------------------------------
    // State and decode
    //------------------------------------------------------------------
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_DECODE = 6'b000010,
        S_EOD = 6'b000100,
        S_ERASE = 6'b001000,
        S_XFER = 6'b010000,
        S_DONE = 6'b100000
    } teci_state_t;

    teci_state_t state_reg;
    teci_cmd_t cmd_reg;
    logic [2:0] lun_reg;
    logic [7:0] count_reg;
    logic [7:0] len_reg;
    logic [1:0] sel_reg;
    teci_done_t result_reg;
    logic attn_reg;
    logic fifo_ready;
    teci_byte_t push_word;
    logic push_valid;
    logic [7:0] avail;
    logic page_ok;
    logic vpd;
    logic legal;
    logic newer_fmt;
    logic [7:0] xfer_len;

    // Position legality per recorded format.
    function automatic logic pos_legal(input teci_fmt_t f, input teci_pos_t p);
        logic ok;
        ok = 1'b0;
        case (p)
            TECI_POS_TAPE_START, TECI_POS_EOD, TECI_POS_LFM_FRONT: ok = 1'b1;
            TECI_POS_LFM_BACK: ok = (f == TECI_FMT_MID) || (f == TECI_FMT_NATIVE);
            TECI_POS_PART_START, TECI_POS_SM_FRONT, TECI_POS_SM_BACK:
                ok = (f == TECI_FMT_NATIVE);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Decode of the held command block.
    always_comb begin
        vpd = cmd_reg.flags[TECI_VPD_BIT];
        legal = pos_legal(fmt_in, pos_in);
        newer_fmt = (fmt_in != TECI_FMT_OLD);
        avail = TECI_LEN_STD;
        page_ok = 1'b1;
        if (!vpd) begin
            page_ok = (cmd_reg.page == TECI_PAGE_LIST);
        end else if (cmd_reg.page == TECI_PAGE_LIST) begin
            avail = TECI_LEN_LIST;
        end else if (cmd_reg.page == TECI_PAGE_SERIAL) begin
            avail = TECI_LEN_SERIAL;
        end else begin
            page_ok = 1'b0;
        end
        // The smaller of the two counts ends the data-in phase.
        xfer_len = (cmd_reg.alloc < avail) ? cmd_reg.alloc : avail;
    end

    //------------------------------------------------------------------
    // Sequencer
    //------------------------------------------------------------------
    // One command at a time; the next is taken only from idle.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_reg <= S_IDLE;
            cmd_reg <= '0;
            lun_reg <= '0;
            len_reg <= TECI_CNT_RESET;
            sel_reg <= '0;
            result_reg <= '0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (cmd_valid_in) begin
                        cmd_reg <= cmd_in;
                        lun_reg <= cmd_in.flags[7:TECI_LUN_LSB] | ident_lun_in;
                        state_reg <= S_DECODE;
                    end
                end
                S_DECODE: begin
                    result_reg <= '{TECI_ST_GOOD, TECI_SK_NONE};
                    state_reg <= S_DONE;
                    if (cmd_reg.opcode == TECI_OP_INQUIRY) begin
                        // Neither reservation nor unit attention blocks inquiry.
                        if (!page_ok) begin
                            result_reg <= '{TECI_ST_CHECK, TECI_SK_ILLEGAL};
                        end else if (xfer_len != 8'h00) begin
                            len_reg <= xfer_len;
                            sel_reg <= {vpd, cmd_reg.page[7]};
                            state_reg <= S_XFER;
                        end
                    end else if (reserved_other_in) begin
                        result_reg <= '{TECI_ST_CONFLICT, TECI_SK_NONE};
                    end else if (attn_reg) begin
                        result_reg <= '{TECI_ST_CHECK, TECI_SK_UNIT_ATTN};
                    end else if (cmd_reg.opcode != TECI_OP_ERASE) begin
                        result_reg <= '{TECI_ST_CHECK, TECI_SK_ILLEGAL};
                    end else if (!legal) begin
                        result_reg <= '{TECI_ST_CHECK, TECI_SK_ILLEGAL};
                    end else if (!cmd_reg.flags[TECI_LONG_BIT]) begin
                        state_reg <= S_DONE; // Accepted with no motion.
                    end else if (newer_fmt && !eod_present_in) begin
                        state_reg <= S_EOD;
                    end else begin
                        state_reg <= S_ERASE;
                    end
                end
                S_EOD: begin
                    // Erase waits until the end-of-data mark is on tape.
                    if (eod_done_in) begin
                        state_reg <= S_ERASE;
                    end
                end
                S_ERASE: begin
                    state_reg <= S_DONE;
                end
                S_XFER: begin
                    if (push_valid && fifo_ready && push_word.last) begin
                        state_reg <= S_DONE;
                    end
                end
                S_DONE: begin
                    state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Byte counter for the response stream.
    always_ff @(posedge mclk_in) begin
        if (srst_in || state_reg != S_XFER) begin
            count_reg <= TECI_CNT_RESET;
        end else if (push_valid && fifo_ready) begin
            count_reg <= count_reg + 8'h01;
        end
    end

    // Byte 0 carries qualifier and type, byte 1 of a VPD page its page code; other content is filled downstream.
    always_comb begin
        push_valid = (state_reg == S_XFER);
        push_word.last = (count_reg + 8'h01 == len_reg);
        push_word.sel = sel_reg;
        push_word.index = count_reg[6:0];
        push_word.data = 8'h00;
        if (count_reg == 8'h00) begin
            push_word.data = (lun_reg != 3'h0) ? TECI_TYPE_BADLUN : TECI_TYPE_TAPE;
        end else if (count_reg == 8'h01 && sel_reg[1]) begin
            push_word.data = cmd_reg.page;
        end
    end

    //------------------------------------------------------------------
    // Unit attention
    //------------------------------------------------------------------
    // A new event wins over the clear so a reset landing on the
    // reporting command is still seen by the next one.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            attn_reg <= TECI_UA_RESET;
        end else if (attn_event_in) begin
            attn_reg <= 1'b1;
        end else if (state_reg == S_DECODE && cmd_reg.opcode != TECI_OP_INQUIRY
                     && !reserved_other_in) begin
            attn_reg <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // Registered outputs
    //------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            cmd_ready_out <= 1'b0;
            eod_write_out <= 1'b0;
            erase_start_out <= 1'b0;
            done_valid_out <= 1'b0;
            done_out <= '0;
            attn_pending_out <= TECI_UA_RESET;
        end else begin
            cmd_ready_out <= (state_reg == S_IDLE) && !cmd_valid_in;
            eod_write_out <= (state_reg == S_EOD) && !eod_done_in;
            erase_start_out <= (state_reg == S_ERASE);
            done_valid_out <= (state_reg == S_DONE);
            if (state_reg == S_DONE) begin
                done_out <= result_reg;
            end
            attn_pending_out <= attn_reg;
        end
    end

    // Back-pressure from the data-in engine stalls the byte counter.
    teci_fifo #(
        .WIDTH($bits(teci_byte_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .in_valid_in(push_valid),
        .in_data_in(push_word),
        .in_ready_out(fifo_ready),
        .out_valid_out(resp_valid_out),
        .out_data_out(resp_out),
        .out_ready_in(resp_ready_in)
    );

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    logic [7:0] sent_reg;
    longint up_reg;
    always_ff @(posedge mclk_in) begin
        if (srst_in || state_reg == S_DECODE) begin
            sent_reg <= 8'h00;
        end else if (push_valid && fifo_ready) begin
            sent_reg <= sent_reg + 8'h01;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            up_reg <= 0;
        end else if (up_reg < POWERUP_CYC) begin
            up_reg <= up_reg + 1;
        end
    end

    illegal_pos_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        state_reg == S_DECODE && cmd_reg.opcode == TECI_OP_ERASE && !legal && !attn_reg
        && !reserved_other_in |-> ##2 done_valid_out && done_out.sense_key == TECI_SK_ILLEGAL)
        else $error("illegal erase position not rejected");
    erase_legal_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        state_reg == S_ERASE |-> legal)
        else $error("erase started from illegal position");
    // The erase pulse trails the mark-written pulse by exactly two edges when a mark was due.
    eod_first_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        $rose(erase_start_out) && newer_fmt && !eod_present_in |-> $past(eod_done_in, 2))
        else $error("erase began before end-of-data mark");
    inq_no_attn_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        state_reg == S_DECODE && cmd_reg.opcode == TECI_OP_INQUIRY && attn_reg
        |=> attn_reg)
        else $error("inquiry cleared unit attention");
    inq_reserved_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        state_reg == S_DECODE && cmd_reg.opcode == TECI_OP_INQUIRY
        |=> result_reg.status != TECI_ST_CONFLICT)
        else $error("inquiry reported a conflict");
    xfer_len_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        state_reg == S_XFER ##1 state_reg == S_DONE |-> sent_reg == len_reg)
        else $error("wrong number of inquiry bytes");
    zero_alloc_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        state_reg == S_DECODE && cmd_reg.opcode == TECI_OP_INQUIRY && page_ok
        && cmd_reg.alloc == 8'h00 |=> state_reg == S_DONE && result_reg.status == TECI_ST_GOOD)
        else $error("zero allocation mishandled");
    bad_lun_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        push_valid && count_reg == 8'h00 && sel_reg == 2'b00 && lun_reg != 3'h0
        |-> push_word.data == TECI_TYPE_BADLUN)
        else $error("bad unit not reported as 7Fh");
    attn_report_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        state_reg == S_DECODE && cmd_reg.opcode == TECI_OP_ERASE && attn_reg
        && !reserved_other_in |-> ##2 done_out.sense_key == TECI_SK_UNIT_ATTN)
        else $error("unit attention not reported");
    powerup_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        up_reg >= POWERUP_CYC && state_reg == S_IDLE |-> ##1 (cmd_ready_out || cmd_valid_in
        || state_reg != S_IDLE))
        else $error("not ready after power-up limit");

    erase_c: cover property (@(posedge mclk_in) eod_write_out ##[1:20] erase_start_out);
    inq_full_c: cover property (@(posedge mclk_in) push_valid && push_word.last
        && push_word.index == 7'h69);
    stall_c: cover property (@(posedge mclk_in) push_valid && !fifo_ready);
endmodule

// File: bench/teci_drain_model.sv
/*
 Model of the data-in engine that drains the response stream.
 Assumes the block's clock and reset; can drain at full rate or with long pauses.
*/
`timescale 1ns/1ps
module teci_drain_model
    import teci_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic srst_in,
    // Response stream.
    input wire logic resp_valid_in,
    input wire teci_byte_t resp_in,
    output logic resp_ready_out,
    // Bench control and tallies.
    input wire logic slow_in,
    input wire logic clear_in,
    output logic [7:0] count_out,
    output logic [7:0] last_at_out,
    output logic [7:0] first_data_out
);
    logic [3:0] tick_reg;

    // Free-running phase counter for the pauses.
    always_ff @(posedge mclk_in) begin
        tick_reg <= srst_in ? 4'h0 : tick_reg + 4'h1;
    end

    // A slow engine stalls half of every sixteen cycles, long enough to fill the FIFO.
    assign resp_ready_out = !srst_in && !(slow_in && tick_reg[3]);

    // Count accepted bytes and note where the final-byte flag appeared.
    always_ff @(posedge mclk_in) begin
        if (srst_in || clear_in) begin
            count_out <= 8'h00;
            last_at_out <= 8'h00;
            first_data_out <= 8'h00;
        end else if (resp_valid_in && resp_ready_out) begin
            count_out <= count_out + 8'h01;
            if (count_out == 8'h00) begin
                first_data_out <= resp_in.data;
            end
            if (resp_in.last) begin
                last_at_out <= count_out + 8'h01;
            end
        end
    end
endmodule

// File: bench/tape_erase_check_and_inquiry_bench.sv
/*
 Self-checking bench for the erase check and inquiry block.
 Assumes the package and the drain model; commands go one at a time.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tape_erase_check_and_inquiry_bench
    import teci_pkg::*;
;
    // One case: command, drive state, expected status, sense, bytes, motion.
    typedef struct packed {
        logic [7:0] op, fl, pg, al;
        logic [3:0] fmt, pos, misc;
        logic [7:0] st;
        logic [3:0] sk;
        logic [7:0] nb;
        logic [3:0] ex;
    } teci_row_t;
    //----------------------------------------------------------------------
    // Case table: misc is {eod present, reserved, slow drain}, ex is {erase, eod write}.
    //----------------------------------------------------------------------
    localparam logic [67:0] case_rows [0:24] = '{
        68'h19_01_00_00_0_0_8_02_6_00_0,
        68'h19_01_00_00_0_0_8_00_0_00_8,
        68'h19_01_00_00_0_3_8_00_0_00_8,
        68'h19_01_00_00_0_2_0_00_0_00_8,
        68'h19_01_00_00_0_4_8_02_5_00_0,
        68'h19_01_00_00_1_1_8_02_5_00_0,
        68'h19_01_00_00_1_0_0_00_0_00_c,
        68'h19_01_00_00_2_4_8_00_0_00_8,
        68'h19_01_00_00_2_5_8_02_5_00_0,
        68'h19_01_00_00_3_1_0_00_0_00_c,
        68'h19_01_00_00_3_5_8_00_0_00_8,
        68'h19_01_00_00_3_6_8_00_0_00_8,
        68'h19_01_00_00_3_7_8_02_5_00_0,
        68'h19_00_00_00_3_6_0_00_0_00_0,
        68'h19_01_00_00_3_0_c_18_0_00_0,
        68'hff_00_00_00_3_0_8_02_5_00_0,
        68'h12_00_00_ff_3_0_a_00_0_6a_0,
        68'h12_00_00_10_3_0_8_00_0_10_0,
        68'h12_01_00_ff_3_0_8_00_0_06_0,
        68'h12_01_80_0e_3_0_a_00_0_0e_0,
        68'h12_01_80_05_3_0_8_00_0_05_0,
        68'h12_00_00_00_3_0_8_00_0_00_0,
        68'h12_01_81_ff_3_0_8_02_5_00_0,
        68'h12_00_80_ff_3_0_8_02_5_00_0,
        68'h12_00_00_ff_3_0_4_00_0_6a_0
    };
    logic mclk_in = 1'b0;
    logic srst_in = 1'b1;
    logic cmd_valid_in = 1'b0;
    teci_cmd_t cmd_in = '0;
    logic [2:0] ident_lun_in = 3'h0;
    teci_fmt_t fmt_in = TECI_FMT_OLD;
    teci_pos_t pos_in = TECI_POS_TAPE_START;
    logic eod_present_in = 1'b0;
    logic reserved_other_in = 1'b0;
    logic attn_event_in = 1'b0;
    logic eod_done_in = 1'b0;
    logic slow = 1'b0;
    logic clear = 1'b0;
    logic cmd_ready_out, eod_write_out, erase_start_out, resp_valid_out, resp_ready_in;
    logic done_valid_out, attn_pending_out;
    teci_byte_t resp_out;
    teci_done_t done_out;
    logic [7:0] count, last_at, first_data;
    int fails = 0;
    int n_checks = 0;

    teci_core #(.POWERUP_CYC(100), .FIFO_DEPTH(4)) i_dut (.mclk_in(mclk_in), .srst_in(srst_in),
        .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .ident_lun_in(ident_lun_in),
        .cmd_ready_out(cmd_ready_out), .fmt_in(fmt_in), .pos_in(pos_in),
        .eod_present_in(eod_present_in), .reserved_other_in(reserved_other_in),
        .attn_event_in(attn_event_in), .eod_write_out(eod_write_out), .eod_done_in(eod_done_in),
        .erase_start_out(erase_start_out), .resp_valid_out(resp_valid_out), .resp_out(resp_out),
        .resp_ready_in(resp_ready_in), .done_valid_out(done_valid_out), .done_out(done_out),
        .attn_pending_out(attn_pending_out));
    teci_drain_model i_drain (.mclk_in(mclk_in), .srst_in(srst_in),
        .resp_valid_in(resp_valid_out), .resp_in(resp_out), .resp_ready_out(resp_ready_in),
        .slow_in(slow), .clear_in(clear), .count_out(count), .last_at_out(last_at),
        .first_data_out(first_data));

    // Clock at 200 MHz.
    always #2.5 mclk_in = ~mclk_in;

    // Tape motion answers a mark write with a one-cycle done pulse.
    always @(posedge mclk_in) begin
        eod_done_in <= !srst_in && eod_write_out && !eod_done_in;
    end

    // Offer one command for one edge while idle, then check its completion and bytes.
    task automatic run_cmd(input teci_row_t r, input logic [2:0] logical_unit_number);
        int k;
        logic [3:0] er;
        logic ew;
        begin
            er = 4'h0;
            ew = 1'b0;
            for (k = 0; k < 50 && cmd_ready_out !== 1'b1; k++) begin
                @(posedge mclk_in);
                #1;
            end
            @(posedge mclk_in);
            cmd_in <= '{r.op, r.fl, r.pg, 8'h00, r.al, 8'h00};
            fmt_in <= teci_fmt_t'(r.fmt[1:0]);
            pos_in <= teci_pos_t'(r.pos[2:0]);
            {eod_present_in, reserved_other_in, slow} <= r.misc[3:1];
            ident_lun_in <= logical_unit_number;
            cmd_valid_in <= 1'b1;
            clear <= 1'b1;
            @(posedge mclk_in);
            cmd_valid_in <= 1'b0;
            clear <= 1'b0;
            for (k = 0; k < 2000 && done_valid_out !== 1'b1; k++) begin
                @(posedge mclk_in);
                #1;
                er = er + {3'h0, erase_start_out};
                ew = ew | eod_write_out;
            end
            `CHK(done_valid_out, 1'b1)
            `CHK(done_out.status, r.st)
            `CHK(done_out.sense_key, r.sk)
            `CHK(er, {3'h0, r.ex[3]})
            `CHK(ew, r.ex[2])
            for (k = 0; k < 300 && resp_valid_out !== 1'b0; k++) begin
                @(posedge mclk_in);
                #1;
            end
            `CHK(resp_valid_out, 1'b0)
            `CHK(count, r.nb)
            if (r.nb != 8'h00) `CHK(last_at, r.nb)
        end
    endtask

    task automatic report_and_stop;
        begin
            $display("Checks made: %0d, mismatches: %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask

    task automatic do_reset;
        begin
            @(posedge mclk_in);
            srst_in <= 1'b1;
            repeat (10) @(posedge mclk_in);
            srst_in <= 1'b0;
            #1;
        end
    endtask

    //----------------------------------------------------------------------
    // Main sequence: table loop, then attention and unit number cases.
    //----------------------------------------------------------------------
    initial begin
        do_reset();
        foreach (case_rows[i]) run_cmd(case_rows[i], 3'h0);
        do_reset();
        `CHK(attn_pending_out, 1'b1)
        run_cmd(68'h12_00_00_ff_3_0_8_00_0_6a_0, 3'h0);
        `CHK(attn_pending_out, 1'b1)
        `CHK(first_data, TECI_TYPE_TAPE)
        run_cmd(68'h19_01_00_00_3_0_8_02_6_00_0, 3'h0);
        `CHK(attn_pending_out, 1'b0)
        run_cmd(68'h19_01_00_00_3_0_8_00_0_00_8, 3'h0);
        @(posedge mclk_in);
        attn_event_in <= 1'b1;
        @(posedge mclk_in);
        attn_event_in <= 1'b0;
        @(posedge mclk_in);
        #1;
        `CHK(attn_pending_out, 1'b1)
        run_cmd(68'h12_20_00_ff_3_0_8_00_0_6a_0, 3'h0);
        `CHK(first_data, TECI_TYPE_BADLUN)
        run_cmd(68'h12_00_00_ff_3_0_8_00_0_6a_0, 3'h2);
        `CHK(first_data, TECI_TYPE_BADLUN)
        run_cmd(68'h19_01_00_00_3_0_8_02_6_00_0, 3'h0);
        report_and_stop();
    end

    // Watchdog: the whole run needs well under forty thousand cycles.
    initial begin
        #(5 * 40000);
        fails++;
        report_and_stop();
    end
endmodule
